// ===== design/pbh_pkg.sv
// constants and types for the primary bus hold interface
// What this block does
// - read_not_write is high on reads and low on writes.
// - data lines keep the last driven level when nobody drives them.
// - access strobe is asserted on every external read and write.
// - four page strobes, the one matching the accessed region is asserted.
// - outside device pulls ready low; the cycle does not end before ready.
// - on a low hold request the running transaction finishes first.
// - while held, address, data, strobe and read/write are floated.
// - transactions wait while held; resume on hold release or ignore bit.
// - hold acknowledge goes low only once outputs float and traffic stops.
// - hold acknowledge returns high on hold release or ignore bit set.
// - block stays in reset while reset is low.
// - after reset, the reset vector is fetched and execution starts there.
// - with edge select active, the four interrupt lines are edge detected.
// - acknowledge instruction pulses the code marker output.
// - pin float control low floats every output and two-way pin.
package pbh_pkg;
    localparam int ADDR_W    = 24;
    localparam int DATA_W    = 32;
    localparam int PAGE_N    = 4;
    localparam int PAGE_MSB  = 23;
    localparam int PAGE_LSB  = 22;
    localparam logic [23:0] RESET_VEC_ADDR = 24'h000000;
    localparam logic [23:0] ADDR_RST       = 24'h000000;
    localparam logic [31:0] DATA_RST       = 32'h00000000;
    // access age from which the synchronised ready belongs to this access
    localparam logic [1:0]  READY_AGE      = 2'h3;

    typedef enum logic [2:0] {
        ST_RESET  = 3'b000,
        ST_VECTOR = 3'b001,
        ST_IDLE   = 3'b010,
        ST_ACCESS = 3'b011,
        ST_HELD   = 3'b100
    } pbh_state_t;
endpackage

// ===== design/pbh_sync.sv
// two-flop synchroniser for a group of levels
`timescale 1ns/1ns
module pbh_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage1_ff;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_ff <= INIT;
            dout      <= INIT;
        end else begin
            stage1_ff <= din;
            dout      <= stage1_ff;
        end
    end
endmodule // pbh_sync

// ===== design/pbh_bus.sv
// primary bus master with hold handshake, interrupt capture and acknowledge pulse
`timescale 1ns/1ns
module pbh_bus (
    input  wire logic        clk,
    input  wire logic        rst_b,
    // core request side
    input  wire logic        reqValid,
    input  wire logic        reqWrite,
    input  wire logic [23:0] reqAddr,
    input  wire logic [31:0] reqWdata,
    output logic             reqReady,
    output logic             rspValid,
    output logic [31:0]      rspRdata,
    output logic             running,
    output logic [23:0]      startAddr,
    input  wire logic        holdIgnoreBit,
    input  wire logic        ackInstr,
    // pins
    output logic [23:0]      addrLines,
    output logic             addrLinesOe,
    input  wire logic [31:0] dataLinesIn,
    output logic [31:0]      dataLines,
    output logic             dataLinesOe,
    output logic             readNotWrite,
    output logic             readNotWriteOe,
    output logic             accessStrobeB,
    output logic             accessStrobeOe,
    output logic [3:0]       pageSelectStrobesB,
    output logic             pageSelectStrobesOe,
    input  wire logic        ready_b,
    input  wire logic        busReleaseRequest_b,
    output logic             busReleaseAckB,
    output logic             busReleaseAckOe,
    input  wire logic        interruptEdgeSelect,
    input  wire logic [3:0]  extIrqLines_b,
    output logic [3:0]       irqPending,
    output logic             codeMarkerAckB,
    output logic             codeMarkerAckOe,
    input  wire logic        pinFloatControl_b
);
    pbh_pkg::pbh_state_t state_ff, nxt_state;
    logic [23:0] addr_ff;
    logic [31:0] wdata_ff;
    logic        write_ff;
    logic        keepValid_ff;
    logic [31:0] keep_ff;
    logic [3:0]  irqPrev_ff;
    logic        holdReqSync;
    logic        readySync;
    logic        readyB;
    logic [3:0]  irqSync;
    logic [1:0]  accessAge_ff;

    function automatic logic [3:0] page_decode(input logic [23:0] a);
        page_decode = ~(4'h1 << a[pbh_pkg::PAGE_MSB:pbh_pkg::PAGE_LSB]);
    endfunction

    pbh_sync #(.W(2), .INIT(2'b11)) u_sync_ctl (
        .clk   (clk),
        .rst_b (rst_b),
        .din   ({busReleaseRequest_b, ready_b}),
        .dout  ({holdReqSync, readyB})
    );
    pbh_sync #(.W(4), .INIT(4'hF)) u_sync_irq (
        .clk   (clk),
        .rst_b (rst_b),
        .din   (extIrqLines_b),
        .dout  (irqSync)
    );

    assign readySync = ~readyB;
    wire holdActive  = ~holdReqSync & ~holdIgnoreBit;
    wire floatAll    = ~pinFloatControl_b;
    wire inAccess    = (state_ff == pbh_pkg::ST_ACCESS) || (state_ff == pbh_pkg::ST_VECTOR);
    // a low ready still in the synchroniser may belong to the previous access
    wire readyFresh  = (accessAge_ff == pbh_pkg::READY_AGE);
    wire readyOk     = readySync & readyFresh;
    wire cycleDone   = inAccess & readyOk;
    wire takeReq     = (state_ff == pbh_pkg::ST_IDLE) & reqValid & ~holdActive;
    wire busDriven   = (state_ff != pbh_pkg::ST_HELD) & (state_ff != pbh_pkg::ST_RESET) & ~floatAll;
    wire writing     = inAccess & write_ff;
    wire heldAck     = (state_ff == pbh_pkg::ST_HELD) & holdActive;
    wire [1:0]  nxt_accessAge    = !inAccess ? 2'h0 : (readyFresh ? accessAge_ff : accessAge_ff + 2'h1);
    wire [31:0] nxt_dataLines    = writing ? wdata_ff : (keepValid_ff ? keep_ff : dataLines);
    wire [3:0]  nxt_pageStrobesB = inAccess ? page_decode(addr_ff) : 4'hF;
    wire        nxt_pageOe       = ~floatAll & (state_ff != pbh_pkg::ST_RESET);
    wire [3:0]  irqEvent;

    // per line: falling edge in edge mode, low level otherwise
    for (genvar i = 0; i < 4; i++) begin : g_irq
        wire irqFall = irqPrev_ff[i] & ~irqSync[i];
        assign irqEvent[i] = interruptEdgeSelect ? irqFall : ~irqSync[i];
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            pbh_pkg::ST_RESET:  nxt_state = pbh_pkg::ST_VECTOR;
            pbh_pkg::ST_VECTOR: if (readyOk) nxt_state = pbh_pkg::ST_IDLE;
            pbh_pkg::ST_IDLE: begin
                if (holdActive) nxt_state = pbh_pkg::ST_HELD;
                else if (reqValid) nxt_state = pbh_pkg::ST_ACCESS;
            end
            pbh_pkg::ST_ACCESS: if (readyOk) nxt_state = pbh_pkg::ST_IDLE;
            pbh_pkg::ST_HELD:   if (!holdActive) nxt_state = pbh_pkg::ST_IDLE;
            default:            nxt_state = pbh_pkg::ST_RESET;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= pbh_pkg::ST_RESET;
            addr_ff  <= pbh_pkg::ADDR_RST;
            wdata_ff <= pbh_pkg::DATA_RST;
            write_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == pbh_pkg::ST_RESET) begin
                addr_ff  <= pbh_pkg::RESET_VEC_ADDR;
                write_ff <= 1'b0;
            end else if (takeReq) begin
                addr_ff  <= reqAddr;
                wdata_ff <= reqWdata;
                write_ff <= reqWrite;
            end
        end
    end

    // keeper: remember last level seen on the data wires
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            keep_ff      <= pbh_pkg::DATA_RST;
            keepValid_ff <= 1'b0;
        end else begin
            keep_ff      <= dataLinesOe ? dataLines : dataLinesIn;
            keepValid_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reqReady  <= 1'b0;
            rspValid  <= 1'b0;
            rspRdata  <= pbh_pkg::DATA_RST;
            running   <= 1'b0;
            startAddr <= pbh_pkg::ADDR_RST;
        end else begin
            reqReady <= takeReq;
            rspValid <= (state_ff == pbh_pkg::ST_ACCESS) & cycleDone;
            if (cycleDone & ~write_ff) begin
                rspRdata <= dataLinesIn;
            end
            if ((state_ff == pbh_pkg::ST_VECTOR) & cycleDone) begin
                running   <= 1'b1;
                startAddr <= dataLinesIn[23:0];
            end
        end
    end

    // cycles spent in the current access, held once ready may be trusted
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            accessAge_ff <= 2'h0;
        end else begin
            accessAge_ff <= nxt_accessAge;
        end
    end

    // address, data, read/write and strobe pins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addrLines      <= pbh_pkg::ADDR_RST;
            addrLinesOe    <= 1'b0;
            dataLines      <= pbh_pkg::DATA_RST;
            dataLinesOe    <= 1'b0;
            readNotWrite   <= 1'b1;
            readNotWriteOe <= 1'b0;
            accessStrobeB  <= 1'b1;
            accessStrobeOe <= 1'b0;
        end else begin
            addrLines      <= addr_ff;
            addrLinesOe    <= busDriven;
            dataLines      <= nxt_dataLines;
            dataLinesOe    <= busDriven & writing;
            readNotWrite   <= ~writing;
            readNotWriteOe <= busDriven;
            accessStrobeB  <= ~inAccess;
            accessStrobeOe <= busDriven;
        end
    end

    // page strobes and hold acknowledge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pageSelectStrobesB  <= 4'hF;
            pageSelectStrobesOe <= 1'b0;
            busReleaseAckB      <= 1'b1;
            busReleaseAckOe     <= 1'b0;
        end else begin
            pageSelectStrobesB  <= nxt_pageStrobesB;
            pageSelectStrobesOe <= nxt_pageOe;
            busReleaseAckB      <= ~heldAck;
            busReleaseAckOe     <= ~floatAll;
        end
    end

    // interrupt capture and code marker pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irqPrev_ff      <= 4'hF;
            irqPending      <= 4'h0;
            codeMarkerAckB  <= 1'b1;
            codeMarkerAckOe <= 1'b0;
        end else begin
            irqPrev_ff      <= irqSync;
            irqPending      <= irqEvent;
            codeMarkerAckB  <= ~(ackInstr & running);
            codeMarkerAckOe <= ~floatAll;
        end
    end
endmodule // pbh_bus

// ===== sim/pbh_bus_checker.sv
// concurrent checks on the bus master pins
`timescale 1ns/1ns
module pbh_bus_checker (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        reqWrite,
    input wire logic        reqReady,
    input wire logic        rspValid,
    input wire logic        ackInstr,
    input wire logic        holdIgnoreBit,
    input wire logic [23:0] addrLines,
    input wire logic        addrLinesOe,
    input wire logic        dataLinesOe,
    input wire logic        readNotWrite,
    input wire logic        accessStrobeB,
    input wire logic        accessStrobeOe,
    input wire logic [3:0]  pageSelectStrobesB,
    input wire logic        pageSelectStrobesOe,
    input wire logic        ready_b,
    input wire logic        busReleaseRequest_b,
    input wire logic        busReleaseAckB,
    input wire logic        codeMarkerAckB,
    input wire logic        pinFloatControl_b
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_RW: assert property (reqReady |=> readNotWrite == !$past(reqWrite)) else $error("rw level wrong");
    AST_ACCESS_STROBE: assert property (reqReady |=> !accessStrobeB && accessStrobeOe) else $error("no strobe");
    AST_PAGE: assert property (!accessStrobeB && pageSelectStrobesOe |->
        pageSelectStrobesB == ~(4'h1 << addrLines[23:22])) else $error("wrong page strobe");
    AST_RDY: assert property (ready_b [*4] |-> !rspValid) else $error("finished without ready");
    AST_HOLDZ: assert property (!busReleaseAckB |-> !(addrLinesOe || dataLinesOe || accessStrobeOe))
        else $error("held but driving");
    AST_FIN: assert property ($fell(busReleaseAckB) |-> $past(accessStrobeB)) else $error("hold cut access");
    AST_REL: assert property ((busReleaseRequest_b || holdIgnoreBit) [*5] |-> busReleaseAckB)
        else $error("hold ack stuck");
    AST_SHZ: assert property (!pinFloatControl_b |=> !(addrLinesOe || dataLinesOe || accessStrobeOe
        || pageSelectStrobesOe)) else $error("float ignored");
    AST_ACK: assert property (ackInstr |=> !codeMarkerAckB) else $error("no marker pulse");
endmodule // pbh_bus_checker
bind pbh_bus pbh_bus_checker u_chk (.*);

// ===== sim/pbh_mem.sv
// external memory answering strobed cycles after a set wait
`timescale 1ns/1ns
module pbh_mem #(parameter logic [31:0] VEC = 32'h00ABC123) (
    input wire logic        clk,
    input wire logic [3:0]  waitCycles,
    input wire logic [23:0] addrLines,
    input wire logic [31:0] dataLines,
    input wire logic        dataLinesOe,
    input wire logic        readNotWrite,
    input wire logic        accessStrobeB,
    input wire logic        accessStrobeOe,
    output logic            ready_b,
    output logic [31:0]     dataLinesIn
);
    logic [31:0] mem [4];
    logic [31:0] keep = 32'h0;
    int cnt = 0;
    wire sel = !accessStrobeB && accessStrobeOe;
    wire [31:0] rd = addrLines == 24'h0 ? VEC : mem[addrLines[23:22]];
    assign dataLinesIn = dataLinesOe ? dataLines : (sel && readNotWrite ? rd : keep);
    initial ready_b = 1'h1;
    always @(posedge clk) begin
        keep <= dataLinesIn;
        cnt <= sel ? cnt + 1 : 0;
        ready_b <= !(sel && cnt >= waitCycles);
        if (sel && !readNotWrite && !ready_b) mem[addrLines[23:22]] <= dataLines;
    end
endmodule // pbh_mem

// ===== sim/pbh_bus_bench.sv
// testbench for the primary bus master
`timescale 1ns/1ns
module pbh_bus_bench;
    localparam logic [31:0] VEC = 32'h00ABC123;
    logic clk = 1'h0, rst_b = 1'h0, reqValid = 1'h0, reqWrite = 1'h0, holdIgnoreBit = 1'h0, ackInstr = 1'h0;
    logic busReleaseRequest_b = 1'h1, interruptEdgeSelect = 1'h0, pinFloatControl_b = 1'h1, ready_b;
    logic [23:0] reqAddr = 24'h0, addrLines, startAddr;
    logic [31:0] reqWdata = 32'h0, dataLinesIn, dataLines, rspRdata, rd;
    logic [3:0] extIrqLines_b = 4'hF, irqPending, pageSelectStrobesB, waitCycles = 4'h0;
    logic reqReady, rspValid, running, addrLinesOe, dataLinesOe, readNotWrite, readNotWriteOe, accessStrobeB;
    logic accessStrobeOe, pageSelectStrobesOe, busReleaseAckB, busReleaseAckOe, codeMarkerAckB, codeMarkerAckOe;
    int fail_count = 0, comparisons = 0, n, k;
    pbh_bus i_dut (.*);
    pbh_mem #(.VEC(VEC)) i_mem (.*);
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("fail_count %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic waitq(ref logic s, input logic v);
        for (n = 0; n < 100 && s !== v; n++) @(posedge clk);
        if (s !== v) begin
            fail_count++;
            results();
        end
    endtask
    task automatic access(logic w, logic [23:0] a, logic [31:0] d, logic hold);
        reqValid <= 1'h1;
        reqWrite <= w;
        reqAddr <= a;
        reqWdata <= d;
        waitq(reqReady, 1'h1);
        reqValid <= 1'h0;
        if (hold) busReleaseRequest_b <= 1'h0;
        waitq(rspValid, 1'h1);
        rd = rspRdata;
        @(posedge clk);
    endtask
    task automatic cnt();
        k = 0;
        repeat (8) begin
            @(posedge clk);
            k += irqPending[2];
        end
    endtask
    initial forever #4 clk = ~clk;
    initial begin
        repeat (4) @(posedge clk);
        chk("strobe oe in reset", accessStrobeOe, 1'h0);
        rst_b <= 1'h1;
        waitq(running, 1'h1);
        chk("start address", startAddr, VEC[23:0]);
        for (int p = 0; p < 4; p++) begin
            waitCycles <= 4'(p * 2);
            access(1'h1, {2'(p), 22'h10}, 32'hC0DE0000 + p, 1'h0);
            access(1'h0, {2'(p), 22'h10}, 32'h0, 1'h0);
            chk("read back", rd, 32'hC0DE0000 + p);
        end
        access(1'h1, 24'h400020, 32'h5A5AA5A5, 1'h1);
        waitq(busReleaseAckB, 1'h0);
        chk("addr oe held", addrLinesOe, 1'h0);
        reqValid <= 1'h1;
        reqWrite <= 1'h0;
        repeat (10) begin
            @(posedge clk);
            chk("taken while held", reqReady, 1'h0);
        end
        holdIgnoreBit <= 1'h1;
        waitq(busReleaseAckB, 1'h1);
        waitq(reqReady, 1'h1);
        reqValid <= 1'h0;
        waitq(rspValid, 1'h1);
        chk("read with hold ignored", rspRdata, 32'h5A5AA5A5);
        busReleaseRequest_b <= 1'h1;
        interruptEdgeSelect <= 1'h1;
        extIrqLines_b <= 4'hB;
        cnt();
        chk("edge pulses", k, 32'h1);
        holdIgnoreBit <= 1'h0;
        interruptEdgeSelect <= 1'h0;
        @(posedge clk);
        cnt();
        chk("level cycles", k, 32'h8);
        chk("hold ack released", busReleaseAckB, 1'h1);
        chk("kept data level", dataLines, 32'h5A5AA5A5);
        ackInstr <= 1'h1;
        @(posedge clk);
        ackInstr <= 1'h0;
        @(posedge clk);
        chk("marker pulse", codeMarkerAckB, 1'h0);
        @(posedge clk);
        chk("marker end", codeMarkerAckB, 1'h1);
        pinFloatControl_b <= 1'h0;
        repeat (2) @(posedge clk);
        chk("float", {addrLinesOe, dataLinesOe, accessStrobeOe, pageSelectStrobesOe, busReleaseAckOe,
            codeMarkerAckOe, readNotWriteOe}, 1'h0);
        results();
    end
endmodule // pbh_bus_bench
